//--- hdl/dwc_ctrl.v
`timescale 1ns/100ps
// Summary of operation
// [RULE_01] Three write kinds, chosen only by write-enable fall placement.
// [RULE_02] Write enable before column strobe gives write-only cycle, output floats.
// [RULE_03] Early write: data-in captured at column strobe fall, held stable.
// [RULE_04] Late write enable: cell is read out first, then written.
// [RULE_05] Read-write: data-in latched at write-enable fall, write to cycle end.
// [RULE_06] Read-modify-write adds a modify interval before write enable falls.
// [RULE_07] Page mode covers up to one 128-bit row.
// [RULE_08] Page read: row strobe low, column strobe pulsed up to 127 more times.
// [RULE_09] First page bit valid after the limiting access time.
// [RULE_10] Row strobe never low longer than 32 us.
// [RULE_11] Page early write: data captured each column strobe fall.
// [RULE_12] Page read-write: column-to-write delay, then write pulse width.
// [RULE_13] 128 row cycles, one per row, within every 2 ms.
// [RULE_14] Refresh toggles only the row strobe; column strobe stays high.
// [RULE_15] At least 8 row strobe cycles after power-up before access.
// [RULE_16] Data-in setup and hold around later strobe, and from row strobe.
// [RULE_17] Write enable high while column strobe low in reads.
// [RULE_18] Address stable at row and column strobe falling edges.
// [RULE_19] Refresh scheduled between page bursts to meet both deadlines.
`include "dwc_map.vh"
module dwc_ctrl #(
  parameter REFRESH_CYC = `DWC_REFRESH_CYC,
  parameter RAS_MAX_CYC = `DWC_RAS_MAX_CYC
) (
  input wire mclk_in,
  input wire rst_in,
  input wire req_valid_in,
  input wire [2:0] req_cmd_in,
  input wire [6:0] req_row_in,
  input wire [6:0] req_col_in,
  input wire req_wdata_in,
  input wire req_last_in,
  output wire req_ready_out,
  output reg rdata_valid_out,
  output reg rdata_out,
  output reg mod_valid_out,
  output reg mod_data_out,
  input wire mod_data_in,
  output reg init_done_out,
  output reg row_strobe_n_out,
  output reg col_strobe_n_out,
  output reg write_n_out,
  output reg [6:0] addr_out,
  output reg din_out,
  input wire dout_in
);
  localparam integer P_PRE = `DWC_CYC(`DWC_T_PRECHARGE_NS);
  localparam integer P_RCD = `DWC_CYC(`DWC_T_ROW_TO_COL_NS);
  localparam integer P_CAS = `DWC_CYC(`DWC_T_CAS_LOW_NS);
  localparam integer P_ACC = `DWC_CYC(`DWC_T_ACCESS_NS);
  localparam integer P_WS = `DWC_CYC(`DWC_T_WRITE_SETUP_NS);
  localparam integer P_CWD = `DWC_CYC(`DWC_T_COL_TO_WRITE_NS);
  localparam integer P_WP = `DWC_CYC(`DWC_T_WRITE_PULSE_NS);
  localparam integer P_MOD = `DWC_CYC(`DWC_T_MODIFY_NS);
  localparam [7:0] C_PRE = P_PRE[7:0];
  localparam [7:0] C_RCD = P_RCD[7:0];
  localparam [7:0] C_CAS = P_CAS[7:0];
  localparam [7:0] C_ACC = P_ACC[7:0];
  localparam [7:0] C_WS = P_WS[7:0];
  localparam [7:0] C_CWD = P_CWD[7:0];
  localparam [7:0] C_WP = P_WP[7:0];
  localparam [7:0] C_MOD = P_MOD[7:0];
  // Margin left so a page burst ends with one full column cycle to spare
  localparam [15:0] C_PAGE_GUARD = 16'h0040;
  localparam [3:0] S_PRE = 4'h0;
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_RAS = 4'h2;
  localparam [3:0] S_WSET = 4'h3;
  localparam [3:0] S_CAS = 4'h4;
  localparam [3:0] S_WAITWE = 4'h5;
  localparam [3:0] S_MOD = 4'h6;
  localparam [3:0] S_WE = 4'h7;
  localparam [3:0] S_CASUP = 4'h8;
  localparam [3:0] S_NEXT = 4'h9;
  localparam [3:0] S_REF = 4'ha;
  localparam [3:0] S_ROWSET = 4'hb;

  reg [3:0] state_r;
  reg [7:0] tmr_r;
  reg [2:0] cmd_r;
  reg [3:0] warm_r;
  reg [6:0] ref_row_r;
  reg [31:0] ref_cnt_r;
  reg ref_due_r;
  reg [15:0] ras_cnt_r;
  reg [7:0] page_cnt_r;
  reg last_r;
  reg wdata_r;
  reg [6:0] col_r;
  reg auto_ref_r;

  wire is_write = (cmd_r == `DWC_CMD_EWRITE) || (cmd_r == `DWC_CMD_RWRITE) ||
                  (cmd_r == `DWC_CMD_RMW);
  wire late_write = (cmd_r == `DWC_CMD_RWRITE) || (cmd_r == `DWC_CMD_RMW);
  wire tmr_done = (tmr_r == 8'h00);
  wire ras_guard = (ras_cnt_r + C_PAGE_GUARD >= RAS_MAX_CYC[15:0]); // RULE_10
  // Ends a burst before the row strobe limit or page length is reached
  wire page_stop = last_r || (page_cnt_r == {1'b0, `DWC_PAGE_LAST}) || ref_due_r ||
                   ras_guard; // RULE_10 RULE_19
  wire in_burst = (state_r == S_NEXT);

  // Guard drops ready, otherwise a request offered as the row closes would be lost
  assign req_ready_out = init_done_out && !ref_due_r &&
                         ((state_r == S_IDLE) || (in_burst && !ras_guard));

  // ==========================================================
  // Refresh timer
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ref_cnt_r <= 32'h00000000;
      ref_due_r <= 1'b0;
    end else begin
      // Spread 128 row cycles evenly across the 2 ms window
      if (ref_cnt_r >= (REFRESH_CYC / 128) - 1) begin // RULE_13
        ref_cnt_r <= 32'h00000000;
        ref_due_r <= 1'b1;
      end else begin
        ref_cnt_r <= ref_cnt_r + 32'h00000001;
        if (state_r == S_REF && tmr_done && auto_ref_r)
          ref_due_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Strobe sequencer
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= S_PRE;
      tmr_r <= 8'h00;
      cmd_r <= 3'h0;
      warm_r <= 4'h0;
      ref_row_r <= 7'h00;
      ras_cnt_r <= 16'h0000;
      page_cnt_r <= 8'h00;
      last_r <= 1'b0;
      wdata_r <= 1'b0;
      col_r <= 7'h00;
      auto_ref_r <= 1'b0;
      init_done_out <= 1'b0;
      row_strobe_n_out <= 1'b1;
      col_strobe_n_out <= 1'b1;
      write_n_out <= 1'b1;
      addr_out <= 7'h00;
      din_out <= 1'b0;
      rdata_valid_out <= 1'b0;
      rdata_out <= 1'b0;
      mod_valid_out <= 1'b0;
      mod_data_out <= 1'b0;
    end else begin
      rdata_valid_out <= 1'b0;
      mod_valid_out <= 1'b0;
      if (!tmr_done)
        tmr_r <= tmr_r - 8'h01;
      if (!row_strobe_n_out)
        ras_cnt_r <= ras_cnt_r + 16'h0001;
      else
        ras_cnt_r <= 16'h0000;
      case (state_r)
        S_PRE: begin
          if (tmr_done)
            state_r <= S_IDLE;
        end
        S_IDLE: begin
          if (!init_done_out || ref_due_r) begin
            // Warm-up and refresh both use strobe-only row cycles
            addr_out <= ref_row_r; // RULE_18
            cmd_r <= `DWC_CMD_REFRESH;
            auto_ref_r <= 1'b1;
            state_r <= S_ROWSET;
          end else if (req_valid_in) begin
            cmd_r <= req_cmd_in;
            col_r <= req_col_in;
            wdata_r <= req_wdata_in;
            last_r <= req_last_in;
            page_cnt_r <= 8'h00;
            auto_ref_r <= 1'b0;
            addr_out <= req_row_in; // RULE_18
            state_r <= S_ROWSET;
          end
        end
        S_ROWSET: begin
          // Row address gets a full cycle of setup before the row strobe falls
          row_strobe_n_out <= 1'b0; // RULE_18
          if (cmd_r == `DWC_CMD_REFRESH) begin
            tmr_r <= C_CAS; // RULE_14 RULE_15
            state_r <= S_REF;
          end else begin
            tmr_r <= C_RCD;
            state_r <= S_RAS;
          end
        end
        S_REF: begin
          if (tmr_done) begin
            row_strobe_n_out <= 1'b1;
            // A commanded refresh of a chosen row must not advance the rotating row
            if (auto_ref_r)
              ref_row_r <= ref_row_r + 7'h01; // RULE_13
            if (!init_done_out) begin
              warm_r <= warm_r + 4'h1;
              if (warm_r == `DWC_WARMUP - 4'h1)
                init_done_out <= 1'b1; // RULE_15
            end
            tmr_r <= C_PRE;
            state_r <= S_PRE;
          end
        end
        S_RAS: begin
          if (tmr_done) begin
            addr_out <= col_r; // RULE_18
            din_out <= wdata_r;
            if (cmd_r == `DWC_CMD_EWRITE)
              write_n_out <= 1'b0; // RULE_02
            tmr_r <= C_WS;
            state_r <= S_WSET;
          end
        end
        S_WSET: begin
          // Address, data and write enable settle before the column strobe falls
          if (tmr_done) begin
            col_strobe_n_out <= 1'b0; // RULE_01 RULE_03 RULE_11
            if (late_write) begin
              tmr_r <= C_CWD;
              state_r <= S_WAITWE;
            end else begin
              tmr_r <= is_write ? C_CAS : C_ACC;
              state_r <= S_CAS;
            end
          end
        end
        S_CAS: begin
          if (tmr_done) begin
            if (!is_write) begin
              rdata_valid_out <= 1'b1; // RULE_09 RULE_17
              rdata_out <= dout_in;
            end
            col_strobe_n_out <= 1'b1;
            write_n_out <= 1'b1;
            tmr_r <= C_WS;
            state_r <= S_CASUP;
          end
        end
        S_WAITWE: begin
          if (tmr_done) begin
            // Read data is out before write enable falls
            rdata_valid_out <= 1'b1; // RULE_04
            rdata_out <= dout_in;
            if (cmd_r == `DWC_CMD_RMW) begin
              mod_valid_out <= 1'b1; // RULE_06
              mod_data_out <= dout_in;
              tmr_r <= C_MOD;
              state_r <= S_MOD;
            end else begin
              write_n_out <= 1'b0; // RULE_05 RULE_12
              tmr_r <= C_WP;
              state_r <= S_WE;
            end
          end
        end
        S_MOD: begin
          if (tmr_r == C_WS)
            din_out <= mod_data_in; // RULE_16
          if (tmr_done) begin
            write_n_out <= 1'b0; // RULE_05
            tmr_r <= C_WP;
            state_r <= S_WE;
          end
        end
        S_WE: begin
          // Strobes rise together so data hold covers both edges
          if (tmr_done) begin
            col_strobe_n_out <= 1'b1; // RULE_16
            write_n_out <= 1'b1;
            tmr_r <= C_WS;
            state_r <= S_CASUP;
          end
        end
        S_CASUP: begin
          if (tmr_done) begin
            page_cnt_r <= page_cnt_r + 8'h01;
            if (page_stop) begin
              row_strobe_n_out <= 1'b1; // RULE_10
              tmr_r <= C_PRE;
              state_r <= S_PRE;
            end else
              state_r <= S_NEXT; // RULE_07 RULE_08
          end
        end
        S_NEXT: begin
          if (ref_due_r || ras_guard) begin
            row_strobe_n_out <= 1'b1; // RULE_19
            tmr_r <= C_PRE;
            state_r <= S_PRE;
          end else if (req_valid_in) begin
            col_r <= req_col_in;
            wdata_r <= req_wdata_in;
            last_r <= req_last_in;
            tmr_r <= 8'h00;
            state_r <= S_RAS;
          end
        end
        default: state_r <= S_PRE;
      endcase
    end
  end
endmodule // dwc_ctrl

//--- hdl/dwc_map.vh
`ifndef DWC_MAP_VH
`define DWC_MAP_VH
// Command encodings on the user port
`define DWC_CMD_READ 3'h0
`define DWC_CMD_EWRITE 3'h1
`define DWC_CMD_RWRITE 3'h2
`define DWC_CMD_RMW 3'h3
`define DWC_CMD_REFRESH 3'h4
// Geometry
`define DWC_ROWS 8'h80
`define DWC_PAGE_LAST 7'h7f
`define DWC_WARMUP 4'h8
// Phase times in ns, converted at 4 ns per clock (least times round up)
`define DWC_CLK_NS 4
`define DWC_T_PRECHARGE_NS 100
`define DWC_T_ROW_TO_COL_NS 40
`define DWC_T_CAS_LOW_NS 120
`define DWC_T_ACCESS_NS 120
`define DWC_T_WRITE_SETUP_NS 20
`define DWC_T_COL_TO_WRITE_NS 80
`define DWC_T_WRITE_PULSE_NS 60
`define DWC_T_MODIFY_NS 40
`define DWC_T_RAS_LOW_MAX_NS 32000
`define DWC_T_REFRESH_MS 2
`define DWC_CYC(ns) (((ns) + `DWC_CLK_NS - 1) / `DWC_CLK_NS)
`define DWC_RAS_MAX_CYC (`DWC_T_RAS_LOW_MAX_NS / `DWC_CLK_NS)
`define DWC_REFRESH_CYC ((`DWC_T_REFRESH_MS * 1000000) / `DWC_CLK_NS)
`endif

//--- sim/dwc_ctrl_asserts.sv
`timescale 1ns/100ps
// ==========
// Strobe order checks
module dwc_ctrl_asserts #(
  parameter RAS_MAX_CYC = 8000
) (
  input wire mclk_in,
  input wire rst_in,
  input wire req_ready_out,
  input wire init_done_out,
  input wire row_strobe_n_out,
  input wire col_strobe_n_out,
  input wire write_n_out,
  input wire [6:0] addr_out,
  input wire din_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  reg [15:0] low_r;
  reg [3:0] fall_cnt_r;
  reg row_d_r;
  // Counts row strobe falls, saturating, to see warm-up finish only after eight
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fall_cnt_r <= 4'h0;
      row_d_r <= 1'b1;
    end else begin
      row_d_r <= row_strobe_n_out;
      if (row_d_r && !row_strobe_n_out && fall_cnt_r != 4'hf)
        fall_cnt_r <= fall_cnt_r + 4'h1;
    end
  end
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) low_r <= 16'h0000;
    else low_r <= row_strobe_n_out ? 16'h0000 : low_r + 16'h0001;
  end
  sequence s_row_fall; $fell(row_strobe_n_out); endsequence
  sequence s_col_fall; $fell(col_strobe_n_out); endsequence
  sequence s_we_fall; $fell(write_n_out) ##0 !col_strobe_n_out; endsequence
  AST_WARMUP: assert property (!init_done_out |-> !req_ready_out)
    else $error("ready before warm-up");
  AST_WARM_COUNT: assert property ($rose(init_done_out) |-> fall_cnt_r >= 4'h8)
    else $error("warm-up ended before eight row cycles");
  AST_ROW_ADDR: assert property (s_row_fall |-> $stable(addr_out))
    else $error("row address moved");
  AST_COL_ADDR: assert property (s_col_fall |-> $stable(addr_out))
    else $error("column address moved");
  AST_EW_DIN: assert property (s_col_fall ##0 !write_n_out |-> $stable(din_out))
    else $error("early write data moved");
  AST_RW_DIN: assert property (s_we_fall |-> $stable(din_out))
    else $error("late write data moved");
  AST_COL_IN_ROW: assert property (!col_strobe_n_out |-> !row_strobe_n_out)
    else $error("column strobe outside row cycle");
  AST_WE_PULSE: assert property ($fell(write_n_out) |-> !write_n_out [*8])
    else $error("write pulse short");
  AST_ROW_MAX: assert property (low_r <= RAS_MAX_CYC)
    else $error("row strobe low too long");
endmodule // dwc_ctrl_asserts
bind dwc_ctrl dwc_ctrl_asserts #(.RAS_MAX_CYC(RAS_MAX_CYC)) i_chk (.mclk_in(mclk_in),
  .rst_in(rst_in), .req_ready_out(req_ready_out), .init_done_out(init_done_out),
  .row_strobe_n_out(row_strobe_n_out), .col_strobe_n_out(col_strobe_n_out),
  .write_n_out(write_n_out), .addr_out(addr_out), .din_out(din_out));

//--- sim/dwc_mem_model.sv
`timescale 1ns/100ps
// ==========
// Memory device model
module dwc_mem_model #(
  parameter T_RAC = 100,
  parameter T_CAC = 80
) (
  input wire row_n_in,
  input wire col_n_in,
  input wire we_n_in,
  input wire [6:0] addr_in,
  input wire din_in,
  output wire dout_out
);
  reg cell_r [0:16383];
  reg [6:0] row_r = 7'h00;
  reg [13:0] adr_r = 14'h0000;
  reg val_r = 1'b0;
  reg drv_r = 1'b0;
  reg noise_r = 1'b0;
  integer seq_r = 0;
  realtime row_t = 0;
  // Floating output toggles so a stale bit never reads as valid
  always #2 noise_r = ~noise_r;
  assign dout_out = drv_r ? val_r : noise_r;
  always @(negedge row_n_in) begin
    row_r = addr_in;
    row_t = $realtime;
  end
  always @(posedge col_n_in) drv_r = 1'b0;
  always @(negedge we_n_in) if (!col_n_in) cell_r[adr_r] = din_in;
  always @(negedge col_n_in) begin : col_fall
    integer s;
    adr_r = {row_r, addr_in};
    seq_r = seq_r + 1;
    s = seq_r;
    if (!we_n_in) cell_r[adr_r] = din_in;
    else begin
      #(T_CAC);
      if ($realtime < row_t + T_RAC) #(row_t + T_RAC - $realtime);
      if (!col_n_in && s == seq_r) begin
        val_r = cell_r[adr_r];
        drv_r = 1'b1;
      end
    end
  end
endmodule // dwc_mem_model

//--- sim/tb_dram_write_page_refresh_timing.sv
`timescale 1ns/100ps
module tb_dram_write_page_refresh_timing;
  localparam REF_CYC = 25600;
  reg mclk_in = 0, rst_in = 1, v = 0, last = 0, wd = 0, mod = 0, w = 0, mexp = 0;
  reg [2:0] cmd = 3'h0;
  reg [6:0] row = 7'h00, col = 7'h00;
  wire rdy, rv, rd, mv, md, idone, row_n, col_n, we_n, din, dout;
  wire [6:0] addr;
  reg shadow [0:127];
  reg q [$];
  integer bad_count = 0, checks = 0, cyc = 0, falls = 0, i, k, c, n;
  always #2 mclk_in = ~mclk_in;
  dwc_ctrl #(.REFRESH_CYC(REF_CYC), .RAS_MAX_CYC(200)) i_dut (.mclk_in(mclk_in),
    .rst_in(rst_in), .req_valid_in(v), .req_cmd_in(cmd), .req_row_in(row), .req_col_in(col),
    .req_wdata_in(wd), .req_last_in(last), .req_ready_out(rdy), .rdata_valid_out(rv),
    .rdata_out(rd), .mod_valid_out(mv), .mod_data_out(md), .mod_data_in(mod),
    .init_done_out(idone), .row_strobe_n_out(row_n), .col_strobe_n_out(col_n),
    .write_n_out(we_n), .addr_out(addr), .din_out(din), .dout_in(dout));
  dwc_mem_model i_mem (.row_n_in(row_n), .col_n_in(col_n), .we_n_in(we_n), .addr_in(addr),
    .din_in(din), .dout_out(dout));
  task report_and_stop;
    begin
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input got, input exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Read notes are queued only once ready shows the previous op has finished
  task req(input [2:0] cc, input [6:0] cl, input wv, input l, input e);
    begin
      @(negedge mclk_in);
      v = 1;
      cmd = cc;
      row = 7'h05;
      col = cl;
      wd = wv;
      last = l;
      while (rdy !== 1'b1) @(negedge mclk_in);
      if (cc == 3'h0 || cc == 3'h2 || cc == 3'h3) q.push_back(e);
      @(negedge mclk_in);
      v = 0;
    end
  endtask
  always @(negedge row_n) falls = falls + 1;
  always @(negedge mclk_in) begin
    mod <= !(md === 1'b1);
    if (rv === 1'b1 && q.size() > 0) chk(rd, q.pop_front());
    else if (rv === 1'b1) chk(1'b1, 1'b0);
    if (mv === 1'b1) chk(md, mexp);
  end
  always @(posedge mclk_in) begin
    cyc = cyc + 1;
    if (cyc == 80000) begin
      bad_count = bad_count + 1;
      report_and_stop;
    end
  end
  initial begin
    void'($urandom(79));
    repeat (5) @(posedge mclk_in);
    @(negedge mclk_in) rst_in = 0;
    while (idone !== 1'b1) @(negedge mclk_in);
    chk(falls >= 8, 1'b1);
    $display("warm-up test done");
    for (i = 0; i < 128; i = i + 1) begin
      shadow[i] = $urandom;
      req(3'h1, i[6:0], shadow[i], i == 127, 1'b0);
    end
    for (i = 0; i < 128; i = i + 1) req(3'h0, i[6:0], 1'b0, i == 127, shadow[i]);
    $display("page test done");
    for (k = 0; k < 24; k = k + 1) begin
      i = $urandom % 128;
      c = k % 4 + 1;
      w = $urandom;
      mexp = shadow[i];
      if (c != 4) shadow[i] = (c == 3) ? ~shadow[i] : w;
      req(c[2:0], i[6:0], w, 1'b1, mexp);
      req(3'h0, i[6:0], 1'b0, 1'b1, shadow[i]);
    end
    $display("write kinds test done");
    repeat (200) @(negedge mclk_in);
    chk(q.size() == 0, 1'b1);
    chk(falls * REF_CYC >= (cyc - REF_CYC) * 128, 1'b1);
    $display("refresh test done");
    report_and_stop;
  end
endmodule // tb_dram_write_page_refresh_timing
